// [include/stp_regs.vh]
// constants for the scan test port
`ifndef STP_REGS_VH
`define STP_REGS_VH
`define STP_IR_W          4
`define STP_IR_RESET      4'hF
`define STP_IR_BYPASS     4'hF
`define STP_IR_EMUDIR     4'h2
`define STP_IR_IDCODE     4'h1
`define STP_EMUDIR_W      2
`define STP_IDCODE_VAL    32'h0000_1001
`define STP_S_RESET       4'h0
`define STP_S_IDLE        4'h1
`define STP_S_SEL_DR      4'h2
`define STP_S_CAP_DR      4'h3
`define STP_S_SH_DR       4'h4
`define STP_S_EX1_DR      4'h5
`define STP_S_PAU_DR      4'h6
`define STP_S_EX2_DR      4'h7
`define STP_S_UPD_DR      4'h8
`define STP_S_SEL_IR      4'h9
`define STP_S_CAP_IR      4'hA
`define STP_S_SH_IR       4'hB
`define STP_S_EX1_IR      4'hC
`define STP_S_PAU_IR      4'hD
`define STP_S_EX2_IR      4'hE
`define STP_S_UPD_IR      4'hF
`endif

// [verilog/stp_scan_port.v]
// scan test port with emulator pins and global output disable
`timescale 1ns/100ps
`include "stp_regs.vh"
module stp_scan_port
#(
	parameter IDCODE = `STP_IDCODE_VAL // arbitrary value
)
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire        tck,
	input  wire        tms,
	input  wire        tdi,
	input  wire        trst,
	output reg         tdo_o,
	output reg         tdo_oe_n,
	input  wire        emulator_pin_a_i,
	output reg         emulator_pin_a_o,
	output reg         emulator_pin_a_oe_n,
	input  wire        emulator_pin_b_or_output_kill_i,
	output reg         emulator_pin_b_or_output_kill_o,
	output reg         emulator_pin_b_or_output_kill_oe_n,
	input  wire [1:0]  emu_irq_out,
	output reg  [1:0]  emu_irq_in,
	output reg         scan_control,
	output reg         output_disable
);
	reg  [5:0] s1_r;
	reg  [5:0] s2_r;
	reg        tck_d_r;
	reg  [3:0] state_r;
	reg  [3:0] state_nxt;
	reg  [`STP_IR_W-1:0] ir_r;
	reg  [`STP_IR_W-1:0] ir_sh_r;
	reg  [31:0] dr_sh_r;
	reg  [`STP_EMUDIR_W-1:0] emudir_r;
	reg        tdo_r;
	reg        shifting_r;

	wire tck_s  = s2_r[0];
	wire tms_s  = s2_r[1];
	wire tdi_s  = s2_r[2];
	wire trst_s = s2_r[3];
	wire ea_s   = s2_r[4];
	wire eb_s   = s2_r[5];
	wire rise   = tck_s & ~tck_d_r;
	wire fall   = ~tck_s & tck_d_r;
	// disable condition, only meaningful outside scan control
	wire kill   = ~trst_s & ea_s & ~eb_s;
	wire is_sh  = (state_r == `STP_S_SH_DR) | (state_r == `STP_S_SH_IR);
	// every data register, bypass included, shifts out of bit 0
	wire dr_tdo = dr_sh_r[0];

	// tck edges show up about 3 clk late, so tck must stay below clk/8
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1_r <= 6'h00;
			s2_r <= 6'h00;
			tck_d_r <= 1'b0;
		end
		else
		begin
			s1_r <= {emulator_pin_b_or_output_kill_i, emulator_pin_a_i, trst, tdi, tms, tck};
			s2_r <= s1_r;
			tck_d_r <= tck_s;
		end
	end

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			`STP_S_RESET:  state_nxt = tms_s ? `STP_S_RESET  : `STP_S_IDLE;
			`STP_S_IDLE:   state_nxt = tms_s ? `STP_S_SEL_DR : `STP_S_IDLE;
			`STP_S_SEL_DR: state_nxt = tms_s ? `STP_S_SEL_IR : `STP_S_CAP_DR;
			`STP_S_CAP_DR: state_nxt = tms_s ? `STP_S_EX1_DR : `STP_S_SH_DR;
			`STP_S_SH_DR:  state_nxt = tms_s ? `STP_S_EX1_DR : `STP_S_SH_DR;
			`STP_S_EX1_DR: state_nxt = tms_s ? `STP_S_UPD_DR : `STP_S_PAU_DR;
			`STP_S_PAU_DR: state_nxt = tms_s ? `STP_S_EX2_DR : `STP_S_PAU_DR;
			`STP_S_EX2_DR: state_nxt = tms_s ? `STP_S_UPD_DR : `STP_S_SH_DR;
			`STP_S_UPD_DR: state_nxt = tms_s ? `STP_S_SEL_DR : `STP_S_IDLE;
			`STP_S_SEL_IR: state_nxt = tms_s ? `STP_S_RESET  : `STP_S_CAP_IR;
			`STP_S_CAP_IR: state_nxt = tms_s ? `STP_S_EX1_IR : `STP_S_SH_IR;
			`STP_S_SH_IR:  state_nxt = tms_s ? `STP_S_EX1_IR : `STP_S_SH_IR;
			`STP_S_EX1_IR: state_nxt = tms_s ? `STP_S_UPD_IR : `STP_S_PAU_IR;
			`STP_S_PAU_IR: state_nxt = tms_s ? `STP_S_EX2_IR : `STP_S_PAU_IR;
			`STP_S_EX2_IR: state_nxt = tms_s ? `STP_S_UPD_IR : `STP_S_SH_IR;
			`STP_S_UPD_IR: state_nxt = tms_s ? `STP_S_SEL_DR : `STP_S_IDLE;
			default:       state_nxt = `STP_S_RESET;
		endcase
	end

	// tap held in reset while trst low: functional mode
	always @(posedge clk)
	begin
		if (!rst_n || !trst_s)
		begin
			state_r <= `STP_S_RESET;
			ir_r <= `STP_IR_RESET;
			ir_sh_r <= {`STP_IR_W{1'b0}};
			dr_sh_r <= 32'h0000_0000;
			emudir_r <= {`STP_EMUDIR_W{1'b0}};
		end
		else if (rise)
		begin
			state_r <= state_nxt;
			case (state_r)
				`STP_S_CAP_IR:
				begin
					ir_sh_r <= {{(`STP_IR_W-1){1'b0}}, 1'b1};
				end
				`STP_S_SH_IR:
				begin
					ir_sh_r <= {tdi_s, ir_sh_r[`STP_IR_W-1:1]};
				end
				`STP_S_UPD_IR:
				begin
					ir_r <= ir_sh_r;
				end
				// data register length follows the current instruction
				`STP_S_CAP_DR:
				begin
					if (ir_r == `STP_IR_IDCODE)
						dr_sh_r <= IDCODE;
					else if (ir_r == `STP_IR_EMUDIR)
						dr_sh_r <= {30'h0000_0000, emudir_r};
					else
						dr_sh_r <= 32'h0000_0000;
				end
				`STP_S_SH_DR:
				begin
					if (ir_r == `STP_IR_IDCODE)
						dr_sh_r <= {tdi_s, dr_sh_r[31:1]};
					else if (ir_r == `STP_IR_EMUDIR)
						dr_sh_r <= {30'h0000_0000, tdi_s, dr_sh_r[1]};
					else
						dr_sh_r <= {31'h0000_0000, tdi_s};
				end
				`STP_S_UPD_DR:
				begin
					if (ir_r == `STP_IR_EMUDIR)
						emudir_r <= dr_sh_r[`STP_EMUDIR_W-1:0];
				end
				default:
				begin
					ir_r <= ir_r;
				end
			endcase
		end
	end

	// falling edge launches tdo so the host samples a stable bit
	always @(posedge clk)
	begin
		if (!rst_n || !trst_s)
		begin
			tdo_r <= 1'b0;
			shifting_r <= 1'b0;
		end
		else if (fall)
		begin
			shifting_r <= is_sh;
			tdo_r <= (state_r == `STP_S_SH_IR) ? ir_sh_r[0] : dr_tdo;
		end
	end

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			tdo_o <= 1'b0;
			tdo_oe_n <= 1'b1;
			scan_control <= 1'b0;
			output_disable <= 1'b0;
		end
		else
		begin
			scan_control <= trst_s;
			output_disable <= kill;
			tdo_o <= tdo_r;
			tdo_oe_n <= kill | ~shifting_r;
		end
	end

	// emulator pins: released at reset so a host driving them cannot fight us
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			emulator_pin_a_o <= 1'b0;
			emulator_pin_a_oe_n <= 1'b1;
			emulator_pin_b_or_output_kill_o <= 1'b0;
			emulator_pin_b_or_output_kill_oe_n <= 1'b1;
			emu_irq_in <= 2'h0;
		end
		else
		begin
			emulator_pin_a_o <= emu_irq_out[0];
			emulator_pin_b_or_output_kill_o <= emu_irq_out[1];
			// drive emulator pins only under scan control, direction from scan
			emulator_pin_a_oe_n <= ~(trst_s & emudir_r[0]);
			emulator_pin_b_or_output_kill_oe_n <= ~(trst_s & emudir_r[1]);
			emu_irq_in <= trst_s ? {eb_s & ~emudir_r[1], ea_s & ~emudir_r[0]} : 2'h0;
		end
	end
endmodule // stp_scan_port

// [dv/stp_scan_port_asserts.sv]
// checker of the scan test port pins
`timescale 1ns/100ps
module stp_chk
(
	input wire		clk,
	input wire		rst_n,
	input wire		tck,
	input wire		trst,
	input wire		tdo_o,
	input wire		tdo_oe_n,
	input wire		emulator_pin_a_i,
	input wire		emulator_pin_a_oe_n,
	input wire		emulator_pin_b_or_output_kill_i,
	input wire		emulator_pin_b_or_output_kill_oe_n,
	input wire [1:0]	emu_irq_in,
	input wire		scan_control,
	input wire		output_disable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence kill_s; (!trst && emulator_pin_a_i && !emulator_pin_b_or_output_kill_i) [*5]; endsequence
	sequence func_s; (!trst) [*5]; endsequence
	sequence scan_s; trst [*5]; endsequence
	tdo_off_a: assert property (output_disable |-> tdo_oe_n) else $error("tdo on");
	pins_off_a: assert property (output_disable |-> emulator_pin_a_oe_n
		&& emulator_pin_b_or_output_kill_oe_n) else $error("pin on");
	kill_on_a: assert property (kill_s |-> output_disable) else $error("no kill");
	scan_on_a: assert property (scan_s |-> scan_control && !output_disable)
		else $error("scan");
	scan_rise_a: assert property ($rose(trst) |-> ##[1:5] scan_control) else $error("late");
	func_mode_a: assert property (func_s |-> !scan_control && tdo_oe_n) else $error("func");
	irq_gate_a: assert property (func_s |-> emu_irq_in == 2'h0) else $error("irq");
	tdo_fall_a: assert property (!tdo_oe_n && $changed(tdo_o) |-> !$past(tck, 3))
		else $error("tdo edge");
endmodule // stp_chk
bind stp_scan_port stp_chk i_chk (.*);

// [dv/stp_host.sv]
// scan host model driving the test pins
`timescale 1ns/100ps
module stp_host
(
	input wire	clk,
	input wire	tdo_o,
	input wire	tdo_oe_n,
	output reg	tck = 1'h0,
	output reg	tms = 1'h0,
	output reg	tdi = 1'h0
);
	reg	lq = 1'h0;
	// tck rests low between bits; tdo read just before the falling edge
	task step(input m, input d, output q);
	begin
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk);
		tck <= 1'h1;
		repeat (4) @(posedge clk);
		q = tdo_oe_n ? ~lq : tdo_o; // released line must not look like data
		lq = q;
		tck <= 1'h0;
	end
	endtask
endmodule // stp_host

// [dv/scan_test_port_output_disable_test.sv]
// self-checking bench of the scan test port
`timescale 1ns/100ps
`include "stp_regs.vh"
module scan_test_port_output_disable_test;
	reg		clk = 1'h0;
	reg		rst_n = 1'h0;
	reg		trst = 1'h0;
	reg		a_drv = 1'h1;
	reg		b_drv = 1'h1;
	reg [1:0]	emu_irq_out = 2'h3;
	reg [31:0]	got;
	reg		q;
	integer		error_cnt = 0;
	integer		checked = 0;
	wire		tck, tms, tdi, tdo_o, tdo_oe_n, scan_control, output_disable;
	wire		emulator_pin_a_o, emulator_pin_a_oe_n;
	wire		emulator_pin_b_or_output_kill_o, emulator_pin_b_or_output_kill_oe_n;
	wire [1:0]	emu_irq_in;
	wire		emulator_pin_a_i = emulator_pin_a_oe_n ? a_drv : emulator_pin_a_o;
	wire		emulator_pin_b_or_output_kill_i = emulator_pin_b_or_output_kill_oe_n ?
			b_drv : emulator_pin_b_or_output_kill_o;
	wire [2:0]	oe_n = {tdo_oe_n, emulator_pin_a_oe_n, emulator_pin_b_or_output_kill_oe_n};
	always #12.5 clk = ~clk;
	stp_scan_port i_dut (.*);
	stp_host i_host (.*);
	task chk(input ok);
	begin
		checked = checked + 1;
		if (!ok)
		begin
			error_cnt = error_cnt + 1;
			$display("BAD %0t mismatch", $time);
		end
	end
	endtask
	task close_out;
	begin
		$display("mismatches %0d of %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	// flags lag the pins by 3 clk
	task wt;
		repeat (6) @(posedge clk);
	endtask
	task walk(input integer n, input [31:0] t, input [31:0] d);
		integer i;
	begin
		for (i = 0; i < n; i = i + 1)
		begin
			i_host.step(t[i], d[i], q);
			got[i] = q;
		end
	end
	endtask
	task t_scan;
	begin
		walk(10, 32'h0DF, 32'h0);
		wt;
		chk(oe_n === 3'h7 && scan_control === 1'h0);
		trst <= 1'h1;
		wt;
		chk(scan_control === 1'h1);
		walk(10, 32'h0DF, 32'h0);
		wt;
		chk(tdo_oe_n === 1'h0);
		walk(4, 32'h8, `STP_IR_IDCODE);
		chk(got[3:0] === 4'h1);
		walk(5, 32'h05, 32'h0);
		walk(32, 32'h8000_0000, 32'h0);
		chk(got === `STP_IDCODE_VAL);
	end
	endtask
	task t_emu;
	begin
		walk(5, 32'h07, 32'h0);
		walk(4, 32'h8, `STP_IR_EMUDIR);
		walk(5, 32'h05, 32'h0);
		walk(4, 32'h6, 32'h1);
		wt;
		chk(oe_n[1:0] === 2'h1 && emulator_pin_a_o === 1'h1 && emu_irq_in[1] === 1'h1);
		chk(emulator_pin_b_or_output_kill_o === 1'h1 && emu_irq_in[0] === 1'h0);
		b_drv <= 1'h0;
		wt;
		chk(emu_irq_in[1] === 1'h0 && output_disable === 1'h0);
	end
	endtask
	task t_kill;
	begin
		trst <= 1'h0;
		wt;
		chk(output_disable === 1'h1 && oe_n === 3'h7);
		b_drv <= 1'h1;
		wt;
		chk(output_disable === 1'h0);
	end
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		t_scan;
		t_emu;
		t_kill;
		close_out;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		error_cnt = error_cnt + 1;
		close_out;
	end
endmodule // scan_test_port_output_disable_test
